// ===== test/smq_host_model.sv
`timescale 1ns/1ps
module smq_host_model
    import smq_pkg::*;
(
    input wire logic clk,
    input wire logic rdy,
    output logic cmd_valid,
    output smq_cmd_t cmd
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // one request, held until the edge that samples ready high
    task automatic send(input smq_op_t o, input smq_set_t s, input logic [15:0] d,
                        input logic [15:0] hi);
        int n;
        n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{op: o, sel: s, data: d, code_hi: hi};
        while (rdy !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        // released fields show no stale value
        cmd.data = ~d;
        cmd.code_hi = ~hi;
    endtask
endmodule

// ===== test/smq_status_queue_tb_top.sv
`timescale 1ns/1ps
module smq_status_queue_tb_top;
    import smq_pkg::*;
    logic REF_CLK;
    logic RST_N;
    logic CMD_VALID;
    smq_cmd_t CMD;
    logic MSG_VALID;
    logic signed [15:0] MSG_CODE;
    smq_cond_t COND;
    logic CMD_READY;
    logic RSP_VALID;
    logic [15:0] RSP_DATA;
    logic [2:0] SUMMARY;
    logic [15:0] exp_q[$];
    logic signed [15:0] codes[$];
    int mismatches;
    int n_compared;
    localparam logic [15:0] VALID_OF [3] = '{MEAS_VALID, QUES_VALID, OPER_VALID};
    localparam logic signed [15:0] F_CODE [7] = '{-110, -222, -150, -223, -230, -5, -109};
    localparam logic [15:0] F_EXP [7] = '{1, 1, 1, 0, 1, 0, 0};

    smq_status_queue smq_status_queue_i (
        .REF_CLK(REF_CLK),
        .RST_N(RST_N),
        .CMD_VALID(CMD_VALID),
        .CMD(CMD),
        .MSG_VALID(MSG_VALID),
        .MSG_CODE(MSG_CODE),
        .COND(COND),
        .CMD_READY(CMD_READY),
        .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA),
        .SUMMARY(SUMMARY)
    );
    smq_host_model smq_host_model_i (
        .clk(REF_CLK),
        .rdy(CMD_READY),
        .cmd_valid(CMD_VALID),
        .cmd(CMD)
    );

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    // replies are matched against the oldest note
    always @(negedge REF_CLK) begin
        if (RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("wrong value at %0t: seen %h expected none", $time, RSP_DATA);
            end else begin
                check(RSP_DATA, exp_q.pop_front());
            end
        end
    end

    task automatic query(input smq_op_t o, input smq_set_t s, input logic [15:0] d,
                         input logic [15:0] e);
        exp_q.push_back(e);
        smq_host_model_i.send(o, s, d, d);
    endtask

    task automatic post(input logic signed [15:0] c);
        @(negedge REF_CLK);
        MSG_VALID = 1'b1;
        MSG_CODE = c;
        @(negedge REF_CLK);
        MSG_VALID = 1'b0;
        MSG_CODE = ~c;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        while (CMD_READY !== 1'b1 && n < 3000) begin
            @(negedge REF_CLK);
            n++;
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge REF_CLK);
        mismatches++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end

    initial begin
        logic [15:0] v;
        logic signed [15:0] c;
        RST_N = 1'b0;
        MSG_VALID = 1'b0;
        MSG_CODE = '0;
        COND = '0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(48));
        idle(20);
        check({11'h0, RSP_VALID, CMD_READY, SUMMARY}, 16'h0);
        check(RSP_DATA, 16'h0);
        RST_N = 1'b1;
        wait_rdy();
        // enable registers per set, including all-ones and refused set
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? 16'd544 : (k == 1) ? 16'hffff : (k == 2) ? 16'h0 : 16'($urandom);
                smq_host_model_i.send(OP_ENAB_WR, smq_set_t'(s), v, v);
                query(OP_ENAB_RD, smq_set_t'(s), 16'h0, v & VALID_OF[s]);
                query(OP_ENAB_RD, smq_set_t'(s), 16'h0, v & VALID_OF[s]);
            end
        end
        query(OP_ENAB_RD, SET_NONE, 16'h0, 16'h0);
        $display("test enable done");
        // summary gating, event read-clear, preset
        smq_host_model_i.send(OP_PRESET, SET_MEAS, 16'h0, 16'h0);
        for (int s = 0; s < 3; s++) query(OP_ENAB_RD, smq_set_t'(s), 16'h0, 16'h0);
        smq_host_model_i.send(OP_ENAB_WR, SET_MEAS, 16'h0020, 16'h0020);
        @(negedge REF_CLK);
        COND = '{oper: 16'h0, ques: 16'h0010, meas: 16'h0220};
        idle(5);
        check({13'h0, SUMMARY}, 16'h1);
        query(OP_EVENT_RD, SET_MEAS, 16'h0, 16'h0220);
        query(OP_EVENT_RD, SET_MEAS, 16'h0, 16'h0);
        idle(3);
        check({13'h0, SUMMARY}, 16'h0);
        smq_host_model_i.send(OP_ENAB_WR, SET_QUES, 16'h0010, 16'h0010);
        idle(3);
        check({13'h0, SUMMARY}, 16'h2);
        smq_host_model_i.send(OP_PRESET, SET_MEAS, 16'h0, 16'h0);
        idle(3);
        check({13'h0, SUMMARY}, 16'h0);
        query(OP_COND_RD, SET_MEAS, 16'h0, 16'h0220);
        query(OP_EVENT_RD, SET_QUES, 16'h0, 16'h0010);
        $display("test summary done");
        // live conditions, masked by layout
        for (int k = 0; k < 4; k++) begin
            @(negedge REF_CLK);
            COND = {16'($urandom), 16'($urandom), 16'($urandom)};
            idle(3);
            query(OP_COND_RD, SET_MEAS, 16'h0, COND.meas & MEAS_VALID);
            query(OP_COND_RD, SET_QUES, 16'h0, COND.ques & QUES_VALID);
            query(OP_COND_RD, SET_OPER, 16'h0, COND.oper & OPER_VALID);
        end
        $display("test condition done");
        // error queue
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        for (int k = 0; k < 12; k++) begin
            c = 16'(1 + $urandom % 500);
            c = -c;
            codes.push_back(c);
            post(c);
        end
        idle(3);
        for (int k = 0; k < 9; k++) query(OP_QUE_NEXT, SET_MEAS, 16'h0, codes[k]);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_OVERFLOW);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        post(16'sd150);
        post(-16'sd7);
        post(16'sd42);
        idle(3);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, -16'sd7);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, 16'sd42);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        post(-16'sd3);
        post(-16'sd4);
        idle(3);
        smq_host_model_i.send(OP_QUE_CLEAR, SET_MEAS, 16'h0, 16'h0);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        post(-16'sd9);
        idle(3);
        smq_host_model_i.send(OP_PRESET, SET_MEAS, 16'h0, 16'h0);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, -16'sd9);
        $display("test queue done");
        // message filter: range, single, empty list
        smq_host_model_i.send(OP_MSG_ENA_START, SET_MEAS, 16'h0, 16'h0);
        smq_host_model_i.send(OP_MSG_ENA_ADD, SET_MEAS, -16'sd110, -16'sd222);
        smq_host_model_i.send(OP_MSG_ENA_ADD, SET_MEAS, -16'sd230, -16'sd230);
        for (int k = 0; k < 7; k++) query(OP_MSG_ENA_RD, SET_MEAS, F_CODE[k], F_EXP[k]);
        wait_rdy();
        post(-16'sd5);
        post(-16'sd150);
        idle(3);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, -16'sd150);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        smq_host_model_i.send(OP_MSG_ENA_START, SET_MEAS, 16'h0, 16'h0);
        wait_rdy();
        post(-16'sd150);
        idle(3);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        query(OP_MSG_ENA_RD, SET_MEAS, -16'sd150, 16'h0);
        idle(3);
        // second reset in mid-run restores the power-up filter
        RST_N = 1'b0;
        idle(2);
        RST_N = 1'b1;
        idle(2);
        check({11'h0, RSP_VALID, CMD_READY, SUMMARY}, 16'h0);
        wait_rdy();
        post(-16'sd20);
        idle(3);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, -16'sd20);
        query(OP_QUE_NEXT, SET_MEAS, 16'h0, CODE_NONE);
        idle(3);
        check(16'(exp_q.size()), 16'h0);
        $display("test filter done");
        report_and_stop();
    end
endmodule

// ===== verilog/smq_err_queue.sv
`timescale 1ns/1ps
module smq_err_queue
    import smq_pkg::*;
#(
    parameter int DEPTH = QUE_DEPTH_DFLT,
    parameter int CW = $clog2(DEPTH + 1),
    parameter int PW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic signed [15:0] push_code,
    input wire logic pop,
    input wire logic clr,
    output logic signed [15:0] head,
    output logic [CW-1:0] count
);
    logic signed [15:0] mem [DEPTH];
    logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic we, pop_ok;
    logic signed [15:0] wcode;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        rd_d = rd_q;
        wr_d = wr_q;
        cnt_d = cnt_q;
        we = 1'b0;
        pop_ok = 1'b0;
        wcode = push_code;
        if (clr) begin
            rd_d = '0;
            wr_d = '0;
            cnt_d = '0;
        end else begin
            pop_ok = pop && (cnt_q != '0);
            if (pop_ok) begin
                rd_d = ptr_inc(rd_q);
            end
            if (push && (cnt_q != CW'(DEPTH))) begin
                we = 1'b1;
                wr_d = ptr_inc(wr_q);
                if (cnt_q == CW'(DEPTH - 1) && !pop_ok) begin
                    wcode = CODE_OVERFLOW;
                end
            end
            cnt_d = cnt_q + CW'(we) - CW'(pop_ok);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (we && !clr) begin
            mem[wr_q] <= wcode;
        end
    end

    assign head = (cnt_q == '0) ? CODE_NONE : mem[rd_q];
    assign count = cnt_q;

    AST_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
        push && !pop && !clr && cnt_q == CW'(DEPTH - 1)
        |=> cnt_q == CW'(DEPTH) && mem[$past(wr_q)] == CODE_OVERFLOW
        ##1 ($past(pop) || $past(clr) || cnt_q == CW'(DEPTH)))
        else $error("overflow slot handling wrong");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clr |=> cnt_q == '0)
        else $error("queue clear left entries");
endmodule

// ===== verilog/smq_pkg.sv
package smq_pkg;

    // layout of the three enable, event and condition registers
    localparam logic [15:0] MEAS_VALID = 16'h03bf;
    localparam logic [15:0] QUES_VALID = 16'h4110;
    localparam logic [15:0] OPER_VALID = 16'h0430;
    localparam logic [15:0] MASK_RST = 16'h0000;

    localparam int MEAS_RANGE_EXCEEDED = 0;
    localparam int MEAS_BELOW_FIRST_LOWER_BOUND = 1;
    localparam int MEAS_ABOVE_FIRST_UPPER_BOUND = 2;
    localparam int MEAS_BELOW_SECOND_LOWER_BOUND = 3;
    localparam int MEAS_ABOVE_SECOND_UPPER_BOUND = 4;
    localparam int MEAS_RESULT_READY = 5;
    localparam int MEAS_STORE_HOLDS_TWO = 7;
    localparam int MEAS_STORE_HALF_FILLED = 8;
    localparam int MEAS_STORE_FILLED = 9;
    localparam int QUES_TEMP_SUMMARY = 4;
    localparam int QUES_CAL_SUMMARY = 8;
    localparam int QUES_CMD_WARNING = 14;
    localparam int OPER_MEASURING = 4;
    localparam int OPER_TRIGGERING = 5;
    localparam int OPER_IDLE = 10;

    // error queue
    localparam int QUE_DEPTH_DFLT = 10;
    localparam logic signed [15:0] CODE_OVERFLOW = 16'sh015e;
    localparam logic signed [15:0] CODE_NONE = 16'sh0000;

    // message filter table covers codes CODE_MIN..CODE_MAX
    localparam int IDX_W = 10;
    localparam logic signed [15:0] CODE_MIN = -16'sh0200;
    localparam logic signed [15:0] CODE_MAX = 16'sh01ff;
    localparam logic [IDX_W-1:0] IDX_LAST = 10'h3ff;
    // codes at or above this are status messages, blocked at power-up
    localparam logic signed [15:0] STATUS_MIN = 16'sh0064;

    typedef enum logic [3:0] {
        OP_ENAB_WR = 4'h0,
        OP_ENAB_RD = 4'h1,
        OP_COND_RD = 4'h2,
        OP_EVENT_RD = 4'h3,
        OP_PRESET = 4'h4,
        OP_QUE_NEXT = 4'h5,
        OP_QUE_CLEAR = 4'h6,
        OP_MSG_ENA_START = 4'h7,
        OP_MSG_ENA_ADD = 4'h8,
        OP_MSG_ENA_RD = 4'h9
    } smq_op_t;

    typedef enum logic [1:0] {
        SET_MEAS = 2'h0,
        SET_QUES = 2'h1,
        SET_OPER = 2'h2,
        SET_NONE = 2'h3
    } smq_set_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_SWEEP = 3'b100
    } smq_state_t;

    typedef struct packed {
        smq_op_t op;
        smq_set_t sel;
        logic [15:0] data;
        logic [15:0] code_hi;
    } smq_cmd_t;

    typedef struct packed {
        logic [15:0] oper;
        logic [15:0] ques;
        logic [15:0] meas;
    } smq_cond_t;

endpackage

// ===== verilog/smq_status_queue.sv
`timescale 1ns/1ps
module smq_status_queue
    import smq_pkg::*;
#(
    parameter int QUE_DEPTH = QUE_DEPTH_DFLT
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    input wire smq_cmd_t CMD,
    input wire logic MSG_VALID,
    input wire logic signed [15:0] MSG_CODE,
    input wire smq_cond_t COND,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic [2:0] SUMMARY
);
    localparam int CW = $clog2(QUE_DEPTH + 1);
    localparam logic [2:0][15:0] SET_VALID = {OPER_VALID, QUES_VALID, MEAS_VALID};

    smq_state_t state_q, state_d;
    logic [IDX_W-1:0] idx_q, idx_d, end_q, end_d;
    logic fill_q, fill_d, dflt_q, dflt_d;
    logic ready_q, ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [15:0] rsp_data_q, rsp_data_d;

    logic ena_mem [2**IDX_W];
    logic wr_val;

    logic [2:0][15:0] cond_arr, en_arr, ev_arr, cnd_arr;
    logic [2:0] sum_arr;
    logic [2:0] en_wr, ev_rd;
    logic preset, que_pop, que_clr, post, acc, sel_ok;
    logic signed [15:0] que_head;
    logic [CW-1:0] que_cnt;
    logic signed [15:0] a_code, b_code, lo_code, hi_code, lo_clip, hi_clip;
    logic add_ok;

    function automatic logic in_range(input logic signed [15:0] c);
        return (c >= CODE_MIN) && (c <= CODE_MAX);
    endfunction

    function automatic logic [IDX_W-1:0] code_idx(input logic signed [15:0] c);
        logic [15:0] off;
        off = c - CODE_MIN;
        return off[IDX_W-1:0];
    endfunction

    function automatic logic msg_default(input logic [IDX_W-1:0] i);
        logic signed [15:0] c;
        c = $signed({6'h00, i}) + CODE_MIN;
        return c < STATUS_MIN;
    endfunction

    assign cond_arr = {COND.oper, COND.ques, COND.meas};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_set
            smq_status_set #(
                .VALID(SET_VALID[g])
            ) u_set (
                .clk(REF_CLK),
                .rst_n(RST_N),
                .cond(cond_arr[g]),
                .en_wr(en_wr[g]),
                .en_data(CMD.data),
                .preset(preset),
                .ev_rd(ev_rd[g]),
                .en_q(en_arr[g]),
                .ev_q(ev_arr[g]),
                .cond_q(cnd_arr[g]),
                .sum_q(sum_arr[g])
            );
        end
    endgenerate

    smq_err_queue #(
        .DEPTH(QUE_DEPTH)
    ) u_queue (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .push(post),
        .push_code(MSG_CODE),
        .pop(que_pop),
        .clr(que_clr),
        .head(que_head),
        .count(que_cnt)
    );

    // list range, normalised and clipped to the table
    always_comb begin
        a_code = $signed(CMD.data);
        b_code = $signed(CMD.code_hi);
        lo_code = (a_code < b_code) ? a_code : b_code;
        hi_code = (a_code < b_code) ? b_code : a_code;
        lo_clip = (lo_code < CODE_MIN) ? CODE_MIN : lo_code;
        hi_clip = (hi_code > CODE_MAX) ? CODE_MAX : hi_code;
        add_ok = lo_clip <= hi_clip;
    end

    // command decode and reply
    always_comb begin
        acc = CMD_VALID && ready_q;
        sel_ok = CMD.sel != SET_NONE;
        en_wr = 3'h0;
        ev_rd = 3'h0;
        preset = 1'b0;
        que_pop = 1'b0;
        que_clr = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        if (acc) begin
            unique case (CMD.op)
                OP_ENAB_WR: begin
                    if (sel_ok) begin
                        en_wr[CMD.sel] = 1'b1;
                    end
                end
                OP_ENAB_RD: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = sel_ok ? en_arr[CMD.sel] : 16'h0000;
                end
                OP_COND_RD: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = sel_ok ? cnd_arr[CMD.sel] : 16'h0000;
                end
                OP_EVENT_RD: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = sel_ok ? ev_arr[CMD.sel] : 16'h0000;
                    if (sel_ok) begin
                        ev_rd[CMD.sel] = 1'b1;
                    end
                end
                OP_PRESET: begin
                    preset = 1'b1;
                end
                OP_QUE_NEXT: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = que_head;
                    que_pop = 1'b1;
                end
                OP_QUE_CLEAR: begin
                    que_clr = 1'b1;
                end
                OP_MSG_ENA_RD: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = {15'h0000, in_range(a_code) && ena_mem[code_idx(a_code)]};
                end
                default: begin
                end
            endcase
        end
    end

    // filter table sweep: power-up fill, clear-all, range enable
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        end_d = end_q;
        fill_d = fill_q;
        dflt_d = dflt_q;
        unique case (state_q)
            ST_INIT, ST_SWEEP: begin
                if (idx_q == end_q) begin
                    state_d = ST_IDLE;
                    dflt_d = 1'b0;
                end else begin
                    idx_d = idx_q + 1'b1;
                end
            end
            ST_IDLE: begin
                if (acc && CMD.op == OP_MSG_ENA_START) begin
                    state_d = ST_SWEEP;
                    idx_d = '0;
                    end_d = IDX_LAST;
                    fill_d = 1'b0;
                end else if (acc && CMD.op == OP_MSG_ENA_ADD && add_ok) begin
                    state_d = ST_SWEEP;
                    idx_d = code_idx(lo_clip);
                    end_d = code_idx(hi_clip);
                    fill_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        ready_d = state_d == ST_IDLE;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_INIT;
            idx_q <= '0;
            end_q <= IDX_LAST;
            fill_q <= 1'b0;
            dflt_q <= 1'b1;
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            end_q <= end_d;
            fill_q <= fill_d;
            dflt_q <= dflt_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    assign wr_val = dflt_q ? msg_default(idx_q) : fill_q;

    always_ff @(posedge REF_CLK) begin
        if (state_q != ST_IDLE) begin
            ena_mem[idx_q] <= wr_val;
        end
    end

    // only enabled codes reach the queue
    assign post = MSG_VALID && (state_q == ST_IDLE) && in_range(MSG_CODE)
        && ena_mem[code_idx(MSG_CODE)];

    assign CMD_READY = ready_q;
    assign RSP_VALID = rsp_valid_q;
    assign RSP_DATA = rsp_data_q;
    assign SUMMARY = sum_arr;

    AST_PRESET_CLEARS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        preset |=> en_arr == 48'h0)
        else $error("preset left an enable bit set");
    AST_PRESET_KEEPS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        preset && !post |=> $stable(que_cnt))
        else $error("preset changed the queue");
    AST_EMPTY_READ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && CMD.op == OP_QUE_NEXT && que_cnt == '0 |=> RSP_VALID && RSP_DATA == 16'h0000)
        else $error("empty queue read not zero");
    AST_FILTER_BLOCK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        MSG_VALID && !post && !que_clr && !que_pop |=> $stable(que_cnt))
        else $error("blocked message entered queue");
    AST_INIT_EMPTY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state_q == ST_INIT |-> que_cnt == '0 && !CMD_READY)
        else $error("queue not empty during start-up");
    AST_READ_NO_SIDE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && (CMD.op == OP_ENAB_RD || CMD.op == OP_COND_RD) |=> $stable(en_arr))
        else $error("read changed an enable register");
    // command, filter sweep and register layout checks
    AST_START_SWEEP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && CMD.op == OP_MSG_ENA_START |=> state_q == ST_SWEEP && idx_q == '0 && !fill_q)
        else $error("empty list did not start a clearing sweep");
    AST_ADD_SWEEP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && CMD.op == OP_MSG_ENA_ADD && add_ok
        |=> state_q == ST_SWEEP && fill_q && end_q >= idx_q)
        else $error("list item did not start an enabling sweep");
    AST_SWEEP_BUSY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state_q == ST_SWEEP |-> !dflt_q && !CMD_READY && wr_val == fill_q)
        else $error("sweep wrote a wrong filter value");
    AST_SWEEP_END: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state_q != ST_IDLE && idx_q == end_q |=> state_q == ST_IDLE && CMD_READY)
        else $error("sweep did not end at its last code");
    AST_SWEEP_STEP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state_q != ST_IDLE && idx_q != end_q |=> idx_q == $past(idx_q) + 1'b1)
        else $error("sweep skipped a code");
    AST_POWERUP_FILTER: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        state_q == ST_INIT |-> dflt_q && wr_val == (idx_q < code_idx(STATUS_MIN)))
        else $error("power-up filter value wrong");
    AST_MSG_QUERY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && CMD.op == OP_MSG_ENA_RD |=> RSP_VALID && RSP_DATA[15:1] == 15'h0000)
        else $error("enabled query reply malformed");
    AST_ENAB_READBACK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc && CMD.op == OP_ENAB_RD && sel_ok
        |=> RSP_VALID && RSP_DATA == $past(en_arr[CMD.sel]))
        else $error("enable query did not return the stored mask");
    AST_QUES_TOP_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !en_arr[SET_QUES][15] && !ev_arr[SET_QUES][15] && !cnd_arr[SET_QUES][15])
        else $error("questionable bit 15 set");
endmodule

// ===== verilog/smq_status_set.sv
`timescale 1ns/1ps
module smq_status_set
    import smq_pkg::*;
#(
    parameter logic [15:0] VALID = MEAS_VALID
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] cond,
    input wire logic en_wr,
    input wire logic [15:0] en_data,
    input wire logic preset,
    input wire logic ev_rd,
    output logic [15:0] en_q,
    output logic [15:0] ev_q,
    output logic [15:0] cond_q,
    output logic sum_q
);
    logic [15:0] en_d;
    logic [15:0] ev_d;
    logic [15:0] rise;
    logic sum_d;
    logic [15:0] cond_d;

    always_comb begin
        rise = cond & ~cond_q & VALID;
        cond_d = cond & VALID;
        en_d = en_q;
        if (preset) begin
            en_d = MASK_RST;
        end else if (en_wr) begin
            en_d = en_data & VALID;
        end
        // a rise in the read cycle survives the clear
        ev_d = (ev_rd ? 16'h0000 : ev_q) | rise;
        sum_d = |(ev_q & en_q);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= MASK_RST;
            ev_q <= 16'h0000;
            cond_q <= 16'h0000;
            sum_q <= 1'b0;
        end else begin
            en_q <= en_d;
            ev_q <= ev_d;
            cond_q <= cond_d;
            sum_q <= sum_d;
        end
    end

    AST_EN_STORE: assert property (@(posedge clk) disable iff (!rst_n)
        en_wr && !preset |=> en_q == ($past(en_data) & VALID))
        else $error("enable write not stored");
    AST_MASK_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
        ((ev_q & en_q) == 16'h0000) |=> !sum_q)
        else $error("masked event reached summary");
    AST_UNMASK_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (|(cond & ~cond_q & VALID & en_q)) && !en_wr && !preset |=> ##1 sum_q)
        else $error("unmasked event did not set summary");
    AST_EVENT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        ev_rd && ((cond & ~cond_q & VALID) == 16'h0000) |=> ev_q == 16'h0000)
        else $error("event read did not clear");
endmodule
